// ==== gpio_irq_pkg.sv ====
// Purpose: Shared constants for the pin interrupt latch and de-bounce block
// Assumes: 32-bit APB data, byte addresses, nine pins
// Notes:   Each offset, field position and reset value is named here once
package gpio_irq_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned PIN_COUNT  = 9;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 32;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] LATCH_CLEAR_OFFSET  = 8'h20;
  localparam logic [7:0] DEBOUNCE_EN_OFFSET  = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFFSET     = 8'h30;
  localparam logic [7:0] FILTERED_PIN_OFFSET = 8'h34;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned PIN_FIELD_LSB = 0;
  localparam int unsigned PIN_FIELD_MSB = 8;
  localparam logic [8:0]  DEBOUNCE_EN_RESET = 9'h000;
  localparam logic [8:0]  IRQ_MASK_RESET    = 9'h000;
  localparam logic [8:0]  LATCH_RESET       = 9'h000;

  // ==========================================================================
  // Bus answer values
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// ==== pin_filter_if.sv ====
// Purpose: Carrier between the de-bounce stage and the interrupt latches
// Assumes: All signals on the bus clock
// Notes:   raw and tick come from the top's synchronisers
`timescale 1ns/10ps
interface pin_filter_if #(
  parameter int unsigned N = 9
);
  logic [N-1:0] raw;       // Synchronised pin levels
  logic         tick;      // One-cycle pulse per slow clock rising edge
  logic [N-1:0] db_en;     // Per-pin de-bounce enables
  logic [N-1:0] filtered;  // Level seen by interrupt detection

  modport filter (input raw, input tick, input db_en, output filtered);
  modport detect (input filtered);
  modport source (output raw, output tick, output db_en);
endinterface

// ==== pin_debounce.sv ====
// Purpose: Per-pin de-bounce filter sampled on slow clock ticks
// Assumes: tick is a single-cycle pulse on pclk
// Notes:   A disabled pin passes its raw level and keeps the filter primed
`timescale 1ns/10ps
module pin_debounce #(
  parameter int unsigned N = 9
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pins in, filtered out
  pin_filter_if.filter pf
);
  import gpio_irq_pkg::*;

  logic [N-1:0] samp_a_ff;
  logic [N-1:0] samp_b_ff;
  logic [N-1:0] stable_ff;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      // Two successive slow-clock samples of the pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          samp_a_ff[g] <= 1'b0;
          samp_b_ff[g] <= 1'b0;
        end else if (pf.tick) begin
          samp_a_ff[g] <= pf.raw[g];
          samp_b_ff[g] <= samp_a_ff[g];
        end
      end

      // Accept a new level only once two samples agree on it
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stable_ff[g] <= 1'b0;
        end else if (!pf.db_en[g]) begin
          stable_ff[g] <= pf.raw[g];
        end else if (samp_a_ff[g] == samp_b_ff[g]) begin
          stable_ff[g] <= samp_b_ff[g];
        end
      end

      // Filtered or raw level toward detection
      assign pf.filtered[g] = pf.db_en[g] ? stable_ff[g] : pf.raw[g];
    end
  endgenerate

endmodule // pin_debounce

// ==== pin_irq_latch.sv ====
// Purpose: Per-pin interrupt detection and sticky latches
// Assumes: Configuration inputs are on pclk
// Notes:   sense high selects high level or rising edge
`timescale 1ns/10ps
module pin_irq_latch #(
  parameter int unsigned N = 9
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Filtered pins
  pin_filter_if.detect      pf,
  // Configuration
  input  wire logic [N-1:0] is_input,
  input  wire logic [N-1:0] irq_enable,
  input  wire logic [N-1:0] mode_edge,
  input  wire logic [N-1:0] sense_high,
  input  wire logic [N-1:0] both_edge,
  // Clear pulses and latch state
  input  wire logic [N-1:0] clear,
  output logic      [N-1:0] latch
);
  import gpio_irq_pkg::*;

  logic [N-1:0] prev_ff;
  logic [N-1:0] latch_ff;
  logic [N-1:0] hit;

  // Previous filtered level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= pf.filtered;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic rise;
      logic fall;
      logic edge_hit;
      logic lvl_hit;
      assign rise     = pf.filtered[g] & ~prev_ff[g];
      assign fall     = ~pf.filtered[g] & prev_ff[g];
      assign edge_hit = both_edge[g] ? (rise | fall)
                                     : (sense_high[g] ? rise : fall);
      assign lvl_hit  = sense_high[g] ? pf.filtered[g] : ~pf.filtered[g];
      assign hit[g]   = is_input[g] & irq_enable[g]
                        & (mode_edge[g] ? edge_hit : lvl_hit);
    end
  endgenerate

  // Sticky latches; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= LATCH_RESET;
    end else begin
      latch_ff <= hit | (latch_ff & ~clear);
    end
  end

  assign latch = latch_ff;

endmodule // pin_irq_latch

// ==== gpio_irq_latch_debounce.sv ====
// Purpose: APB slave for pin interrupt latch clear and de-bounce enable
// Assumes: pclk 20 MHz; pins and slow clock are asynchronous to it
// Notes:   Latches drive the interrupt through a mask but are never readable
//
// Chosen here: the APB register port.
`timescale 1ns/10ps

// What this block does
// - Matching pin event sets a held latch
// - Writing one clears only that pin's latch
// - Zero writes ignored; clear register reads zero
// - No readable path to latch state
// - Active level re-sets latch right after clear
// - Filter sits before interrupt detection
// - Filter samples on the slow clock
// - Change must persist two slow cycles
// - De-bounce enable bit n controls pin n
// - Mode bit: zero level, one edge
// - Both-edge bit overrides sense in edge mode
// - Detect only on enabled input pins
module gpio_irq_latch_debounce #(
  parameter int unsigned N = gpio_irq_pkg::PIN_COUNT
) (
  // APB clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // APB request
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [gpio_irq_pkg::ADDR_WIDTH-1:0] paddr,
  input  wire logic [gpio_irq_pkg::DATA_WIDTH-1:0] pwdata,
  input  wire logic [3:0]                          pstrb,
  // APB answer
  output logic      [gpio_irq_pkg::DATA_WIDTH-1:0] prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Pins and slow clock
  input  wire logic [N-1:0]                        pin_in,
  input  wire logic                                slow_clock,
  // Per-pin configuration from the port's other registers
  input  wire logic [N-1:0]                        pin_is_input,
  input  wire logic [N-1:0]                        pin_interrupt_enable,
  input  wire logic [N-1:0]                        pin_interrupt_mode_select,
  input  wire logic [N-1:0]                        pin_interrupt_sense_select,
  input  wire logic [N-1:0]                        pin_interrupt_both_edge_select,
  // Interrupt
  output logic                                     irq
);
  import gpio_irq_pkg::*;

  // ==========================================================================
  // Declarations
  logic [N-1:0]  pin_s1_ff;
  logic [N-1:0]  pin_s2_ff;
  logic          slow_s1_ff;
  logic          slow_s2_ff;
  logic          slow_s3_ff;
  logic [N-1:0]  debounce_en_ff;
  logic [N-1:0]  irq_mask_ff;
  logic [N-1:0]  clear_ff;
  logic [N-1:0]  latch;
  logic [31:0]   prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic          irq_ff;
  logic          setup;
  logic          wr_take;
  logic [31:0]   nxt_prdata;
  logic          nxt_err;

  // Address match against one register offset
  function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] a,
                                   input logic [7:0] off);
    reg_hit = (a == off[ADDR_WIDTH-1:0]);
  endfunction

  // Merge write data into a pin-wide field under byte strobes
  function automatic logic [N-1:0] strb_merge(input logic [N-1:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    strb_merge = (old & ~m[N-1:0]) | (wd[N-1:0] & m[N-1:0]);
  endfunction

  // ==========================================================================
  // Synchronisers
  // Two flops on each pin before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Slow clock synchronised, third flop finds its rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_s1_ff <= 1'b0;
      slow_s2_ff <= 1'b0;
      slow_s3_ff <= 1'b0;
    end else begin
      slow_s1_ff <= slow_clock;
      slow_s2_ff <= slow_s1_ff;
      slow_s3_ff <= slow_s2_ff;
    end
  end

  // ==========================================================================
  // Filter and latches
  pin_filter_if #(.N(N)) pf ();

  assign pf.raw   = pin_s2_ff;
  assign pf.tick  = slow_s2_ff & ~slow_s3_ff;
  assign pf.db_en = debounce_en_ff;

  pin_debounce #(.N(N)) u_debounce (
    .pclk    (pclk),
    .presetn (presetn),
    .pf      (pf.filter)
  );

  pin_irq_latch #(.N(N)) u_latch (
    .pclk       (pclk),
    .presetn    (presetn),
    .pf         (pf.detect),
    .is_input   (pin_is_input),
    .irq_enable (pin_interrupt_enable),
    .mode_edge  (pin_interrupt_mode_select),
    .sense_high (pin_interrupt_sense_select),
    .both_edge  (pin_interrupt_both_edge_select),
    .clear      (clear_ff),
    .latch      (latch)
  );

  // ==========================================================================
  // APB slave
  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & pready_ff & pwrite;

  // Read data and error chosen in the setup cycle
  always_comb begin
    nxt_prdata = READ_ZERO;
    nxt_err    = 1'b0;
    if (reg_hit(paddr, LATCH_CLEAR_OFFSET)) begin
      nxt_prdata = READ_ZERO;
    end else if (reg_hit(paddr, DEBOUNCE_EN_OFFSET)) begin
      nxt_prdata[N-1:0] = debounce_en_ff;
    end else if (reg_hit(paddr, IRQ_MASK_OFFSET)) begin
      nxt_prdata[N-1:0] = irq_mask_ff;
    end else if (reg_hit(paddr, FILTERED_PIN_OFFSET)) begin
      nxt_prdata[N-1:0] = pf.filtered;
    end else begin
      nxt_err = 1'b1;
    end
  end

  // One wait-free access phase: ready rises after each setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= READ_ZERO;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_err;
      if (setup && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end else if (!setup) begin
        prdata_ff <= READ_ZERO;
      end
    end
  end

  // De-bounce enables, reset to off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debounce_en_ff <= DEBOUNCE_EN_RESET;
    end else if (wr_take && reg_hit(paddr, DEBOUNCE_EN_OFFSET)) begin
      debounce_en_ff <= strb_merge(debounce_en_ff, pwdata, pstrb);
    end
  end

  // Interrupt mask over the latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= IRQ_MASK_RESET;
    end else if (wr_take && reg_hit(paddr, IRQ_MASK_OFFSET)) begin
      irq_mask_ff <= strb_merge(irq_mask_ff, pwdata, pstrb);
    end
  end

  // One-cycle clear pulse per written one; zeros do nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_ff <= '0;
    end else if (wr_take && reg_hit(paddr, LATCH_CLEAR_OFFSET)) begin
      clear_ff <= strb_merge('0, pwdata, pstrb);
    end else begin
      clear_ff <= '0;
    end
  end

  // ==========================================================================
  // Interrupt output, level while any unmasked latch is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(latch & irq_mask_ff);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

endmodule // gpio_irq_latch_debounce

// ==== gpio_irq_monitor.sv ====
// Purpose: Port-level checks of the latch-clear and de-bounce APB block
// Assumes: One clock domain, master keeps psel up through the access cycle
// Notes:   Mirrors the de-bounce enables to check their read-back
`timescale 1ns/10ps
module gpio_irq_monitor #(
  parameter int unsigned N = 9
) (
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // APB
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [3:0]   pstrb,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // Configuration and interrupt
  input wire logic [N-1:0] pin_interrupt_enable,
  input wire logic         irq
);
  logic [8:0] db_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Mirror of the de-bounce enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) db_ff <= 9'h000;
    else if (psel && penable && pready && pwrite && paddr == 8'h24) begin
      if (pstrb[0]) db_ff[7:0] <= pwdata[7:0];
      if (pstrb[1]) db_ff[8] <= pwdata[8];
    end
  end
  // ==========================================================================
  // Assertions
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_only_access_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  slverr_map_a: assert property (pready |->
    pslverr == !(paddr inside {8'h20, 8'h24, 8'h30, 8'h34}))
    else $error("pslverr wrong for address");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read");
  clr_reads_zero_a: assert property (
    pready && !pwrite && paddr == 8'h20 |-> prdata == 32'h0)
    else $error("latch clear read not zero");
  dbe_readback_a: assert property (
    pready && !pwrite && paddr == 8'h24 |-> prdata == {23'h0, db_ff})
    else $error("de-bounce enables read wrong");
  clear_all_a: assert property (
    (pin_interrupt_enable == 9'h000) [*4] ##0 (pready && pwrite
    && paddr == 8'h20 && pwdata[8:0] == 9'h1ff && pstrb[1:0] == 2'h3)
    |=> (pin_interrupt_enable == 9'h000) [*2] |=> !irq)
    else $error("irq stays after clearing all latches");
  // Main scenarios
  clear_wr_c: cover property (pready && pwrite && paddr == 8'h20);
  irq_rise_c: cover property ($rose(irq));
  slverr_c: cover property (pslverr);
endmodule // gpio_irq_monitor

bind gpio_irq_latch_debounce gpio_irq_monitor #(.N(N)) gpio_irq_monitor_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .pin_interrupt_enable, .irq);

// ==== pin_source.sv ====
// Purpose: External pin levels and a free-running kilohertz clock
// Assumes: The slow clock runs scaled down for simulation
// Notes:   Its phase is unrelated to pclk
`timescale 1ns/10ps
module pin_source (
  // Requested levels
  input  wire logic [8:0] level,
  // Pins and slow clock
  output logic      [8:0] pin,
  output logic            slow_clock
);
  // Pins follow the request after a short wire delay
  assign #7 pin = level;
  // Slow clock, about twenty pclk periods
  initial begin
    slow_clock = 1'b0;
    forever #510 slow_clock = ~slow_clock;
  end
endmodule // pin_source

// ==== test_gpio_irq_latch_debounce.sv ====
// Purpose: Self-checking bench for the latch-clear and de-bounce block
// Assumes: pclk 50 ns, inputs changed by non-blocking assignment at edges
// Notes:   Only one pin interrupt is enabled at a time
`timescale 1ns/10ps
module test_gpio_irq_latch_debounce;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, slow_clock, irq, err;
  logic [8:0]  level = 9'h000, pin_in, c_in = 9'h1ff, c_en = 9'h000;
  logic [8:0]  c_edge = 9'h000, c_sense = 9'h1ff, c_both = 9'h000;
  int          num_errors = 0, comparisons = 0;
  // ==========================================================================
  // Design and pin partner
  gpio_irq_latch_debounce gpio_irq_latch_debounce_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pin_in, .slow_clock, .pin_is_input(c_in),
    .pin_interrupt_enable(c_en), .pin_interrupt_mode_select(c_edge),
    .pin_interrupt_sense_select(c_sense),
    .pin_interrupt_both_edge_select(c_both), .irq);
  pin_source pin_source_i (.level, .pin(pin_in), .slow_clock);
  always #25 pclk = ~pclk;
  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= {4{w}};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
    apb(1'b0, a, 32'h0);
    check("read data", rd, e);
    check("slave error", {31'h0, err}, {31'h0, ee});
  endtask
  task automatic irq_is(input int n, input logic e);
    repeat (n) @(posedge pclk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask
  // ==========================================================================
  // Scenarios
  task automatic s_regs;
    rdchk(8'h24, 32'h0, 1'b0);
    wr(8'h24, 32'h0000_01ff);
    rdchk(8'h24, 32'h0000_01ff, 1'b0);
    wr(8'h24, 32'h0000_0000);
    rdchk(8'h20, 32'h0, 1'b0);
    rdchk(8'h40, 32'h0, 1'b1);
    wr(8'h30, 32'h0000_01ff);
    rdchk(8'h30, 32'h0000_01ff, 1'b0);
  endtask
  task automatic s_level;
    c_en <= 9'h001;
    level <= 9'h001;
    irq_is(8, 1'b1);
    rdchk(8'h34, 32'h0000_0001, 1'b0);
    wr(8'h30, 32'h0);
    irq_is(2, 1'b0);
    wr(8'h30, 32'h0000_01ff);
    irq_is(2, 1'b1);
    wr(8'h20, 32'h0);
    irq_is(4, 1'b1);
    wr(8'h20, 32'h0000_0001);
    irq_is(4, 1'b1);
    level <= 9'h000;
    irq_is(8, 1'b1);
    wr(8'h20, 32'h0000_0001);
    irq_is(4, 1'b0);
    c_sense <= 9'h1fe;
    irq_is(4, 1'b1);
    c_sense <= 9'h1ff;
    wr(8'h20, 32'h0000_0001);
    irq_is(4, 1'b0);
  endtask
  task automatic s_edge;
    c_en <= 9'h002;
    c_edge <= 9'h002;
    level <= 9'h002;
    irq_is(8, 1'b1);
    wr(8'h20, 32'h0000_0002);
    irq_is(4, 1'b0);
    level <= 9'h000;
    irq_is(8, 1'b0);
    c_sense <= 9'h1fd;
    level <= 9'h002;
    irq_is(8, 1'b0);
    level <= 9'h000;
    irq_is(8, 1'b1);
    wr(8'h20, 32'h0000_0002);
    c_sense <= 9'h1ff;
    irq_is(4, 1'b0);
    c_both <= 9'h002;
    level <= 9'h002;
    irq_is(8, 1'b1);
    wr(8'h20, 32'h0000_0002);
    level <= 9'h000;
    irq_is(8, 1'b1);
    wr(8'h20, 32'h0000_01fd);
    irq_is(4, 1'b1);
    wr(8'h20, 32'h0000_0002);
    irq_is(4, 1'b0);
  endtask
  task automatic s_gate;
    c_en <= 9'h008;
    c_in <= 9'h1f7;
    level <= 9'h008;
    irq_is(8, 1'b0);
    c_in <= 9'h1ff;
    irq_is(8, 1'b1);
    c_en <= 9'h000;
    irq_is(5, 1'b1);
    wr(8'h20, 32'h0000_01ff);
    irq_is(4, 1'b0);
    level <= 9'h000;
  endtask
  task automatic s_debounce;
    wr(8'h24, 32'h0000_0010);
    c_en <= 9'h010;
    c_edge <= 9'h010;
    level <= 9'h010;
    irq_is(3, 1'b0);
    level <= 9'h000;
    irq_is(50, 1'b0);
    level <= 9'h010;
    irq_is(10, 1'b0);
    irq_is(60, 1'b1);
    wr(8'h20, 32'h0000_0010);
    irq_is(4, 1'b0);
  endtask
  task automatic s_reset;
    wr(8'h24, 32'h0000_01ff);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    irq_is(1, 1'b0);
    rdchk(8'h24, 32'h0, 1'b0);
    rdchk(8'h30, 32'h0, 1'b0);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs;
    s_level;
    s_edge;
    s_gate;
    s_debounce;
    s_reset;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    conclude;
  end
endmodule // test_gpio_irq_latch_debounce
